// ==== common/vgcr_pkg.sv ====
package vgcr_pkg;
  // Coprocessor register number and select of each register in this bank.
  localparam logic [4:0] REG_GUEST_CONTROL_EXTENSION = 5'h0b;
  localparam logic [2:0] SEL_GUEST_CONTROL_EXTENSION = 3'h4;
  localparam logic [4:0] REG_GUEST_TIME_OFFSET = 5'h0c;
  localparam logic [2:0] SEL_GUEST_TIME_OFFSET = 3'h7;
  localparam logic [4:0] REG_EXCEPTION_CAUSE = 5'h0d;
  localparam logic [2:0] SEL_EXCEPTION_CAUSE = 3'h0;
  localparam logic [4:0] REG_CAPABILITY_CONFIG_THREE = 5'h10;
  localparam logic [2:0] SEL_CAPABILITY_CONFIG_THREE = 3'h3;
  localparam logic [4:0] REG_WATCHPOINT_HIGH = 5'h13;
  localparam logic [2:0] SEL_WATCHPOINT_HIGH = 3'h0;
  localparam logic [4:0] REG_PERF_CONTROL = 5'h19;
  localparam logic [2:0] SEL_PERF_CONTROL = 3'h0;
  localparam logic [4:0] REG_GUEST_COUNT = 5'h09;
  localparam logic [2:0] SEL_GUEST_COUNT = 3'h0;

  // Extension register field positions.
  localparam int EXT_MMU_BIT = 0;
  localparam int EXT_BAD_BIT = 1;
  localparam int EXT_OTHER_BIT = 2;
  localparam int EXT_FCD_BIT = 3;
  localparam int EXT_CGI_BIT = 4;
  localparam int EXT_WIDTH = 5;
  localparam logic [4:0] EXT_RESET = 5'h00;

  // Cause, capability, watchpoint, performance control and offset fields, and the index-invalidate op code.
  localparam int CAUSE_CODE_LSB = 2;
  localparam logic [4:0] EXC_CODE_GUEST_EXIT = 5'h1b;
  localparam logic [4:0] EXC_CODE_RESET = 5'h00;
  localparam int VZ_BIT = 23;
  localparam int WM_LSB = 28;
  localparam logic [1:0] WM_RESET = 2'h0;
  localparam int ASID_LSB = 16;
  localparam int EC_LSB = 23;
  localparam logic [1:0] EC_RESET = 2'h0;
  localparam logic [31:0] OFFSET_RESET = 32'h0000_0000;
  localparam logic [15:0] CACHE_INDEX_INVALIDATE = 16'hb000;

  // Event-context encodings.
  localparam logic [1:0] EC_ROOT = 2'h0;
  localparam logic [1:0] EC_ROOT_INTERVENTION = 2'h1;
  localparam logic [1:0] EC_GUEST = 2'h2;
  localparam logic [1:0] EC_GUEST_PLUS_INTERVENTION = 2'h3;

  // Register group touched by a guest coprocessor access.
  typedef enum logic [2:0] {
    GRP_NONE,
    GRP_OTHER,
    GRP_BAD,
    GRP_MMU,
    GRP_COUNT
  } vgcr_group_t;
endpackage : vgcr_pkg

// ==== hw/vgcr_regs.sv ====
// How it works
// [RULE1] Op 0xb000 runs untrapped when both guest cache bits are set.
// [RULE2] Field-change events trap unless field-change-disable is set.
// [RULE3] Enables in bits 2,1,0 make guest accesses to their groups trap.
// [RULE4] Clear group enable means no trap unless coprocessor access is off.
// [RULE5] Optional extension bits reset to 0; unimplemented ones read 0.
// [RULE6] Guest time equals root count plus the two's complement offset.
// [RULE7] Guest time matching compare gives the timer event; reads show it.
// [RULE8] Guest writes to guest count always trap and never change guest time; a guest cache op in the same cycle overrides this trap.
// [RULE9] Offset width is nonzero; unimplemented offset bits read zero.
// [RULE10] Offset is read/write from root and resets to zero.
// [RULE11] Guest exit loads cause code 27 and the subcode into guest control.
// [RULE12] Capability is read-only; bit 23 shows virtualization presence.
// [RULE13] Guest reads of the virtualization bit always return 0.
// [RULE14] Explicit invalid entry marking reported with guest identifiers.
// [RULE15] Watch identifier is 10 bits with extended identifiers, else 8.
// [RULE16] Watch management bits 29:28 reset 0, root writable, guest reads 0.
// [RULE17] Event-context field selects what counts; root-only writable.
// [RULE18] Guest time wraps modulo 2^32; unimplemented offset bits are zero.
`timescale 1ns/1ns
module vgcr_regs #(
  parameter logic [4:0] EXT_IMPL = 5'h1f,
  parameter int OFFSET_WIDTH = 32,
  parameter bit VIRT_PRESENT = 1'b1,
  parameter bit GUEST_ID_SUPPORTED = 1'b1,
  parameter bit WATCH_MGMT_IMPL = 1'b1,
  parameter bit EVENT_CONTEXT_IMPL = 1'b1,
  parameter logic [31:0] CAPABILITY_CONFIG_THREE_OTHER = 32'h0000_0000
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Coprocessor register port.
  input wire logic regRead,
  input wire logic regWrite,
  input wire logic [4:0] regNum,
  input wire logic [2:0] regSel,
  input wire logic [31:0] regWriteData,
  input wire logic rootMode,
  input wire logic guestContext,
  output logic [31:0] regReadData,
  // Guest control state held elsewhere.
  input wire logic cacheGuestEnable,
  input wire logic guestCoprocAccess,
  input wire logic extendedAsidEnable,
  // Guest access checks.
  input wire logic guestAccess,
  input wire logic guestAccessWrite,
  input wire vgcr_pkg::vgcr_group_t guestAccessGroup,
  input wire logic guestCacheOp,
  input wire logic [15:0] cacheOpCode,
  input wire logic guestSoftwareFieldChange,
  input wire logic guestHardwareFieldChange,
  output logic guestPrivilegedSensitiveExc,
  output logic fieldChangeExc,
  output logic fieldChangeApply,
  // Exceptions.
  input wire logic excTake,
  input wire logic [4:0] excCodeIn,
  input wire logic guestExit,
  input wire logic [7:0] guestExitDetail,
  output logic [7:0] guestExitSubcode,
  // Guest timer.
  input wire logic [31:0] rootCount,
  input wire logic [31:0] guestCompare,
  output logic [31:0] guestTime,
  output logic guestTimerIrq,
  // Performance counting.
  input wire logic perfEvent,
  input wire logic ctxRoot,
  input wire logic ctxRootIntervention,
  input wire logic ctxGuest,
  output logic perfCount,
  // Capability.
  output logic explicitInvalidEntry
);
  localparam logic [31:0] OFFSET_MASK = (OFFSET_WIDTH >= 32) ? 32'hffff_ffff
    : ((32'h1 << OFFSET_WIDTH) - 32'h1);

  wire logic [4:0] guestControlExtension;
  logic [31:0] guestTimeOffset;
  logic [4:0] exceptionCode;
  logic [1:0] watchManagement;
  logic [9:0] watchAsid;
  logic [1:0] eventContextSelect;
  logic [31:0] next_guestTime;
  logic [31:0] next_readData;
  logic next_guest_privileged_sensitive_exc;
  logic matchPrev;
  logic rootWrite;
  logic [31:0] capabilityConfigThree;
  logic [31:0] watchpointHigh;
  logic [9:0] asidMask;

  assign rootWrite = regWrite && rootMode;

  // Each optional extension bit exists only where its function is built.
  genvar b;
  generate
    for (b = 0; b < vgcr_pkg::EXT_WIDTH; b++)
    begin : g_ext
      if (EXT_IMPL[b])
      begin : g_impl
        logic extBit;
        always_ff @(posedge clk or posedge rst)
        begin
          if (rst)
            extBit <= vgcr_pkg::EXT_RESET[b]; // [RULE5]
          else if (rootWrite &&
                   regNum == vgcr_pkg::REG_GUEST_CONTROL_EXTENSION &&
                   regSel == vgcr_pkg::SEL_GUEST_CONTROL_EXTENSION)
            extBit <= regWriteData[b];
        end
        assign guestControlExtension[b] = extBit;
      end
      else
      begin : g_none
        assign guestControlExtension[b] = 1'b0; // [RULE5]
      end
    end
  endgenerate

  // The offset stores only implemented bits, so read-back shows the width.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      guestTimeOffset <= vgcr_pkg::OFFSET_RESET; // [RULE10]
    else if (rootWrite && regNum == vgcr_pkg::REG_GUEST_TIME_OFFSET &&
             regSel == vgcr_pkg::SEL_GUEST_TIME_OFFSET)
      guestTimeOffset <= regWriteData & OFFSET_MASK; // [RULE9]
  end

  // Guest exit takes priority over any other exception in the same cycle.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      exceptionCode <= vgcr_pkg::EXC_CODE_RESET;
      guestExitSubcode <= 8'h00;
    end
    else if (guestExit)
    begin
      exceptionCode <= vgcr_pkg::EXC_CODE_GUEST_EXIT; // [RULE11]
      guestExitSubcode <= guestExitDetail; // [RULE11]
    end
    else if (excTake)
      exceptionCode <= excCodeIn;
  end

  assign asidMask = extendedAsidEnable ? 10'h3ff : 10'h0ff; // [RULE15]

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      watchManagement <= vgcr_pkg::WM_RESET; // [RULE16]
      watchAsid <= 10'h000;
    end
    else if (rootWrite && !guestContext &&
             regNum == vgcr_pkg::REG_WATCHPOINT_HIGH &&
             regSel == vgcr_pkg::SEL_WATCHPOINT_HIGH)
    begin
      if (WATCH_MGMT_IMPL)
        watchManagement <= regWriteData[vgcr_pkg::WM_LSB +: 2]; // [RULE16]
      watchAsid <= regWriteData[vgcr_pkg::ASID_LSB +: 10] & asidMask;
    end
  end

  // In guest context the field is read-only zero, so writes are dropped; writes also need root mode.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      eventContextSelect <= vgcr_pkg::EC_RESET;
    else if (EVENT_CONTEXT_IMPL && rootWrite && !guestContext &&
             regNum == vgcr_pkg::REG_PERF_CONTROL &&
             regSel == vgcr_pkg::SEL_PERF_CONTROL)
      eventContextSelect <= regWriteData[vgcr_pkg::EC_LSB +: 2]; // [RULE17]
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      perfCount <= 1'b0;
    else
      case (eventContextSelect)
        vgcr_pkg::EC_ROOT: perfCount <= perfEvent && ctxRoot; // [RULE17]
        vgcr_pkg::EC_ROOT_INTERVENTION:
          perfCount <= perfEvent && ctxRootIntervention; // [RULE17]
        vgcr_pkg::EC_GUEST: perfCount <= perfEvent && ctxGuest; // [RULE17]
        default:
          perfCount <= perfEvent && (ctxGuest || ctxRootIntervention);
      endcase
  end

  // Plain 32-bit add wraps with the root count.
  assign next_guestTime =
    rootCount + (guestTimeOffset & OFFSET_MASK); // [RULE6] [RULE18]

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      guestTime <= 32'h0000_0000;
      matchPrev <= 1'b0;
      guestTimerIrq <= 1'b0;
    end
    else
    begin
      guestTime <= next_guestTime;
      matchPrev <= (next_guestTime == guestCompare);
      // One pulse when the guest time reaches compare, not while it rests.
      guestTimerIrq <= (next_guestTime == guestCompare) && !matchPrev; // [RULE7]
    end
  end

  always_comb
  begin
    next_guest_privileged_sensitive_exc = 1'b0;
    if (guestAccess)
    begin
      case (guestAccessGroup)
        vgcr_pkg::GRP_OTHER: next_guest_privileged_sensitive_exc = !guestCoprocAccess ||
          guestControlExtension[vgcr_pkg::EXT_OTHER_BIT]; // [RULE3] [RULE4]
        vgcr_pkg::GRP_BAD: next_guest_privileged_sensitive_exc = !guestCoprocAccess ||
          guestControlExtension[vgcr_pkg::EXT_BAD_BIT]; // [RULE3] [RULE4]
        vgcr_pkg::GRP_MMU: next_guest_privileged_sensitive_exc = !guestCoprocAccess ||
          guestControlExtension[vgcr_pkg::EXT_MMU_BIT]; // [RULE3] [RULE4]
        vgcr_pkg::GRP_COUNT:
          next_guest_privileged_sensitive_exc = guestAccessWrite || !guestCoprocAccess; // [RULE8]
        default: next_guest_privileged_sensitive_exc = !guestCoprocAccess;
      endcase
    end
    if (guestCacheOp)
    begin
      if (cacheOpCode == vgcr_pkg::CACHE_INDEX_INVALIDATE)
        next_guest_privileged_sensitive_exc = !(cacheGuestEnable &&
          guestControlExtension[vgcr_pkg::EXT_CGI_BIT]); // [RULE1]
      else
        next_guest_privileged_sensitive_exc = !cacheGuestEnable; // [RULE1]
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      guestPrivilegedSensitiveExc <= 1'b0;
      fieldChangeExc <= 1'b0;
      fieldChangeApply <= 1'b0;
      explicitInvalidEntry <= 1'b0;
    end
    else
    begin
      guestPrivilegedSensitiveExc <= next_guest_privileged_sensitive_exc;
      fieldChangeExc <= (guestSoftwareFieldChange ||
        guestHardwareFieldChange) &&
        !guestControlExtension[vgcr_pkg::EXT_FCD_BIT]; // [RULE2]
      fieldChangeApply <= (guestSoftwareFieldChange ||
        guestHardwareFieldChange) &&
        guestControlExtension[vgcr_pkg::EXT_FCD_BIT]; // [RULE2]
      explicitInvalidEntry <= VIRT_PRESENT && GUEST_ID_SUPPORTED; // [RULE14]
    end
  end

  // Capability has no storage; the guest view hides the virtualization bit.
  always_comb
  begin
    capabilityConfigThree = CAPABILITY_CONFIG_THREE_OTHER;
    capabilityConfigThree[vgcr_pkg::VZ_BIT] =
      VIRT_PRESENT && !guestContext; // [RULE12] [RULE13]
    watchpointHigh = 32'h0000_0000;
    watchpointHigh[vgcr_pkg::ASID_LSB +: 10] =
      watchAsid & asidMask; // [RULE15]
    if (!guestContext)
      watchpointHigh[vgcr_pkg::WM_LSB +: 2] = watchManagement; // [RULE16]
  end

  always_comb
  begin
    next_readData = 32'h0000_0000;
    if (guestContext)
    begin
      if (regNum == vgcr_pkg::REG_GUEST_COUNT &&
          regSel == vgcr_pkg::SEL_GUEST_COUNT)
        next_readData = next_guestTime; // [RULE7]
      else if (regNum == vgcr_pkg::REG_CAPABILITY_CONFIG_THREE &&
               regSel == vgcr_pkg::SEL_CAPABILITY_CONFIG_THREE)
        next_readData = capabilityConfigThree; // [RULE13]
      else if (regNum == vgcr_pkg::REG_WATCHPOINT_HIGH &&
               regSel == vgcr_pkg::SEL_WATCHPOINT_HIGH)
        next_readData = watchpointHigh;
    end
    else
      case ({regNum, regSel})
        {vgcr_pkg::REG_GUEST_CONTROL_EXTENSION,
         vgcr_pkg::SEL_GUEST_CONTROL_EXTENSION}:
          next_readData = {27'h0000000, guestControlExtension};
        {vgcr_pkg::REG_GUEST_TIME_OFFSET, vgcr_pkg::SEL_GUEST_TIME_OFFSET}:
          next_readData = guestTimeOffset; // [RULE9]
        {vgcr_pkg::REG_EXCEPTION_CAUSE, vgcr_pkg::SEL_EXCEPTION_CAUSE}:
          next_readData[vgcr_pkg::CAUSE_CODE_LSB +: 5] = exceptionCode;
        {vgcr_pkg::REG_CAPABILITY_CONFIG_THREE,
         vgcr_pkg::SEL_CAPABILITY_CONFIG_THREE}:
          next_readData = capabilityConfigThree; // [RULE12]
        {vgcr_pkg::REG_WATCHPOINT_HIGH, vgcr_pkg::SEL_WATCHPOINT_HIGH}:
          next_readData = watchpointHigh;
        {vgcr_pkg::REG_PERF_CONTROL, vgcr_pkg::SEL_PERF_CONTROL}:
          next_readData[vgcr_pkg::EC_LSB +: 2] = eventContextSelect;
        default: next_readData = 32'h0000_0000;
      endcase
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      regReadData <= 32'h0000_0000;
    else if (regRead)
      regReadData <= next_readData;
  end

  sequence exitSeen_s;
    guestExit;
  endsequence
  sequence causeLoaded_s;
    exceptionCode == vgcr_pkg::EXC_CODE_GUEST_EXIT;
  endsequence

  causeGuestExit_a: assert property (@(posedge clk) disable iff (rst)
    exitSeen_s |=> causeLoaded_s ##0
    guestExitSubcode == $past(guestExitDetail))
    else $error("guest exit did not load cause code 27"); // [RULE11]
  countWriteTrap_a: assert property (@(posedge clk) disable iff (rst)
    guestAccess && guestAccessWrite && guestAccessGroup == vgcr_pkg::GRP_COUNT
    && !guestCacheOp |=> guestPrivilegedSensitiveExc)
    else $error("guest count write did not trap"); // [RULE8]
  fieldChange_a: assert property (@(posedge clk) disable iff (rst)
    guestSoftwareFieldChange |=> fieldChangeExc != fieldChangeApply)
    else $error("field change neither trapped nor applied"); // [RULE2]
  guestTimeSum_a: assert property (@(posedge clk) disable iff (rst)
    guestTime == $past(rootCount) + $past(guestTimeOffset & OFFSET_MASK))
    else $error("guest time is not root count plus offset"); // [RULE6]
  timerPulse_a: assert property (@(posedge clk) disable iff (rst)
    guestTimerIrq |-> guestTime == $past(guestCompare) ##1 !guestTimerIrq)
    else $error("guest timer event mismatched"); // [RULE7]
  offsetWidth_a: assert property (@(posedge clk) disable iff (rst)
    (guestTimeOffset & ~OFFSET_MASK) == 32'h0000_0000)
    else $error("unimplemented offset bits set"); // [RULE9]
  guestVzZero_a: assert property (@(posedge clk) disable iff (rst)
    regRead && guestContext |=> regReadData[vgcr_pkg::VZ_BIT] == 1'b0 ||
    $past(regNum) != vgcr_pkg::REG_CAPABILITY_CONFIG_THREE)
    else $error("guest saw virtualization bit"); // [RULE13]
  mgmtGuestZero_a: assert property (@(posedge clk) disable iff (rst)
    regRead && guestContext && regNum == vgcr_pkg::REG_WATCHPOINT_HIGH
    |=> regReadData[vgcr_pkg::WM_LSB +: 2] == 2'h0)
    else $error("guest saw watch management bits"); // [RULE16]
  indexInval_a: assert property (@(posedge clk) disable iff (rst)
    guestCacheOp && cacheOpCode == vgcr_pkg::CACHE_INDEX_INVALIDATE &&
    cacheGuestEnable && guestControlExtension[vgcr_pkg::EXT_CGI_BIT]
    |=> !guestPrivilegedSensitiveExc)
    else $error("allowed index invalidate trapped"); // [RULE1]
endmodule : vgcr_regs

// ==== bench/tb.sv ====
`timescale 1ns/1ns
module tb;
  localparam int OW = 16;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic regRead = 1'b0, regWrite = 1'b0, rootMode = 1'b1;
  logic guestContext = 1'b0;
  logic [4:0] regNum = 5'h00;
  logic [2:0] regSel = 3'h0;
  logic [31:0] regWriteData = 32'h0, regReadData;
  logic cacheGuestEnable = 1'b0, guestCoprocAccess = 1'b1;
  logic extendedAsidEnable = 1'b0, guestAccess = 1'b0;
  logic guestAccessWrite = 1'b0, guestCacheOp = 1'b0;
  vgcr_pkg::vgcr_group_t guestAccessGroup = vgcr_pkg::GRP_NONE;
  logic [15:0] cacheOpCode = 16'h0;
  logic guestSoftwareFieldChange = 1'b0, guestHardwareFieldChange = 1'b0;
  logic guestPrivilegedSensitiveExc, fieldChangeExc, fieldChangeApply;
  logic excTake = 1'b0, guestExit = 1'b0;
  logic [4:0] excCodeIn = 5'h00;
  logic [7:0] guestExitDetail = 8'h00, guestExitSubcode;
  logic [31:0] rootCount = 32'h0, guestCompare = 32'h0, guestTime;
  logic guestTimerIrq, perfCount, explicitInvalidEntry;
  logic perfEvent = 1'b0, ctxRoot = 1'b0, ctxRootIntervention = 1'b0;
  logic ctxGuest = 1'b0;
  int errCount = 0;
  int nCompared = 0;
  int nIrq = 0;
  logic [31:0] mExt = 32'h0, mOff = 32'h0, wd = 32'h0, we = 32'h0;
  logic pe = 1'b0;

  vgcr_regs #(.OFFSET_WIDTH(OW)) i_dut (
    .clk, .rst, .regRead, .regWrite, .regNum, .regSel, .regWriteData,
    .rootMode, .guestContext, .regReadData, .cacheGuestEnable,
    .guestCoprocAccess, .extendedAsidEnable, .guestAccess,
    .guestAccessWrite, .guestAccessGroup, .guestCacheOp, .cacheOpCode,
    .guestSoftwareFieldChange, .guestHardwareFieldChange,
    .guestPrivilegedSensitiveExc, .fieldChangeExc, .fieldChangeApply,
    .excTake, .excCodeIn, .guestExit, .guestExitDetail, .guestExitSubcode,
    .rootCount, .guestCompare, .guestTime, .guestTimerIrq, .perfEvent,
    .ctxRoot, .ctxRootIntervention, .ctxGuest, .perfCount,
    .explicitInvalidEntry
  );

  always #25 clk = ~clk;

  task automatic stopTest();
    $display("Compared %0d, mismatches %0d", nCompared, errCount);
    if (errCount == 0 && nCompared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : stopTest

  task automatic chk32(input string nm, input logic [31:0] e, g);
    nCompared++;
    if (g !== e)
    begin
      errCount++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk32

  task automatic chk1(input string nm, input logic e, g);
    nCompared++;
    if (g !== e)
    begin
      errCount++;
      $display("MISMATCH %s expected %b seen %b", nm, e, g);
    end
  endtask : chk1

  // One register access; the strobe stays up across exactly one rising edge.
  task automatic acc(input logic wr, rm, gc, input logic [4:0] n,
                     input logic [2:0] s, input logic [31:0] d);
    @(negedge clk);
    regWrite = wr;
    regRead = !wr;
    rootMode = rm;
    guestContext = gc;
    regNum = n;
    regSel = s;
    regWriteData = d;
    @(negedge clk);
    regWrite = 1'b0;
    regRead = 1'b0;
  endtask : acc

  task automatic rd(input string nm, input logic rm, gc,
                    input logic [4:0] n, input logic [2:0] s,
                    input logic [31:0] m, e);
    acc(1'b0, rm, gc, n, s, 32'h0);
    chk32(nm, e & m, regReadData & m);
  endtask : rd

  // Only one kind of check event per cycle, so priority never matters.
  task automatic probe();
    int k;
    logic eg;
    @(negedge clk);
    k = int'($urandom % 4);
    guestCoprocAccess = (k == 1) | 1'($urandom);
    cacheGuestEnable = 1'($urandom);
    guestAccessWrite = 1'($urandom);
    guestAccessGroup = vgcr_pkg::vgcr_group_t'(3'($urandom % 5));
    cacheOpCode = 1'($urandom) ? 16'hb000 : 16'($urandom);
    guestAccess = (k == 0);
    guestCacheOp = (k == 1);
    guestSoftwareFieldChange = (k == 2);
    guestHardwareFieldChange = (k == 3);
    case (guestAccessGroup)
      vgcr_pkg::GRP_OTHER: eg = mExt[2];
      vgcr_pkg::GRP_BAD: eg = mExt[1];
      vgcr_pkg::GRP_MMU: eg = mExt[0];
      vgcr_pkg::GRP_COUNT: eg = guestAccessWrite;
      default: eg = 1'b0;
    endcase
    eg = (k == 0) && (eg || !guestCoprocAccess);
    if (k == 1)
      eg = (cacheOpCode == 16'hb000) ? !(cacheGuestEnable && mExt[4])
                                     : !cacheGuestEnable;
    @(negedge clk);
    guestAccess = 1'b0;
    guestCacheOp = 1'b0;
    guestSoftwareFieldChange = 1'b0;
    guestHardwareFieldChange = 1'b0;
    chk1("trap", eg,
      guestPrivilegedSensitiveExc);
    chk1("fcExc", k > 1 && !mExt[3], fieldChangeExc);
    chk1("fcApply", k > 1 && mExt[3], fieldChangeApply);
  endtask : probe

  initial
  begin
    #2000000;
    errCount++;
    $display("MISMATCH watchdog expected finish seen timeout");
    stopTest();
  end

  initial
  begin
    void'($urandom(32'h8d4b336e));
    repeat (20) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    rd("extRst", 1'b1, 1'b0, 5'h0b, 3'h4, '1, 32'h0);
    rd("offRst", 1'b1, 1'b0, 5'h0c, 3'h7, '1, 32'h0);
    rd("wmRst", 1'b1, 1'b0, 5'h13, 3'h0, 32'h3000_0000, 32'h0);
    rd("ecRst", 1'b1, 1'b0, 5'h19, 3'h0, 32'h0180_0000, 32'h0);
    chk1("invalidEntry", 1'b1, explicitInvalidEntry);
    acc(1'b1, 1'b1, 1'b0, 5'h10, 3'h3, '1);
    rd("capRoot", 1'b1, 1'b0, 5'h10, 3'h3, '1, 32'h0080_0000);
    rd("capGuest", 1'b0, 1'b1, 5'h10, 3'h3, '1, 32'h0);
    rd("unmapped", 1'b1, 1'b0, 5'h1f, 3'h7, '1, 32'h0);
    acc(1'b1, 1'b1, 1'b0, 5'h0b, 3'h4, '1);
    rd("extAll", 1'b1, 1'b0, 5'h0b, 3'h4, '1, 32'h1f);
    acc(1'b1, 1'b0, 1'b0, 5'h0b, 3'h4, 32'h0);
    rd("extNoRoot", 1'b1, 1'b0, 5'h0b, 3'h4, '1, 32'h1f);
    acc(1'b1, 1'b1, 1'b0, 5'h0c, 3'h7, '1);
    rd("offAll", 1'b1, 1'b0, 5'h0c, 3'h7, '1,
      32'h0000_ffff);
    repeat (40)
    begin
      mExt = 32'($urandom) & 32'h1f;
      acc(1'b1, 1'b1, 1'b0, 5'h0b, 3'h4, mExt | 32'hffe0_0000);
      repeat (4) probe();
    end
    // Upper offset bits are written as ones to prove they add nothing.
    mOff = 32'($urandom) & 32'h0000_ffff;
    acc(1'b1, 1'b1, 1'b0, 5'h0c, 3'h7, mOff | 32'hffff_0000);
    rootCount = 32'hffff_ff00;
    repeat (50)
    begin
      @(negedge clk);
      chk32("guestTime", rootCount + mOff, guestTime);
      rootCount = 32'($urandom);
    end
    rd("guestCount", 1'b0, 1'b1, 5'h09, 3'h0, '1, rootCount + mOff);
    acc(1'b1, 1'b0, 1'b1, 5'h09, 3'h0, 32'h0);
    rd("countWr", 1'b0, 1'b1, 5'h09, 3'h0, '1, rootCount + mOff);
    guestCompare = mOff + 32'h0000_000a;
    rootCount = 32'h0;
    repeat (20)
    begin
      @(negedge clk);
      if (guestTimerIrq === 1'b1)
      begin
        nIrq++;
        chk32("irqTime", guestCompare, guestTime);
      end
      rootCount = rootCount + 32'h1;
    end
    chk32("irqCount", 32'h1, 32'(nIrq));
    for (int i = 0; i < 3; i++)
    begin
      @(negedge clk);
      excCodeIn = 5'($urandom_range(0, 26));
      guestExitDetail = 8'($urandom);
      excTake = (i != 1);
      guestExit = (i != 0);
      @(negedge clk);
      excTake = 1'b0;
      guestExit = 1'b0;
      if (i != 0)
        chk32("subcode", 32'(guestExitDetail),
          32'(guestExitSubcode));
      we = (i != 0) ? 32'h6c : 32'(excCodeIn) << 2;
      rd("cause", 1'b1, 1'b0, 5'h0d, 3'h0, 32'h7c, we);
    end
    for (int ec = 0; ec < 4; ec++)
    begin
      acc(1'b1, 1'b1, 1'b0, 5'h19, 3'h0, 32'(ec) << 23);
      acc(1'b1, 1'b1, 1'b1, 5'h19, 3'h0, 32'h0180_0000);
      we = 32'(ec) << 23;
      rd("evCtx", 1'b1, 1'b0, 5'h19, 3'h0, 32'h0180_0000, we);
      repeat (8)
      begin
        @(negedge clk);
        {perfEvent, ctxRoot, ctxRootIntervention, ctxGuest} = 4'($urandom);
        case (ec)
          0: pe = ctxRoot;
          1: pe = ctxRootIntervention;
          2: pe = ctxGuest;
          default: pe = ctxGuest | ctxRootIntervention;
        endcase
        @(negedge clk);
        chk1("perfCount", pe && perfEvent, perfCount);
      end
    end
    for (int ae = 0; ae < 2; ae++)
    begin
      extendedAsidEnable = 1'(ae);
      wd = 32'($urandom);
      acc(1'b1, 1'b1, 1'b0, 5'h13, 3'h0, wd);
      acc(1'b1, 1'b1, 1'b1, 5'h13, 3'h0, ~wd);
      we = wd & ((ae == 1) ? 32'h33ff_0000 : 32'h30ff_0000);
      rd("watch", 1'b1, 1'b0, 5'h13, 3'h0, 32'h33ff_0000,
        we);
      rd("wmGuest", 1'b0, 1'b1, 5'h13, 3'h0, 32'h3000_0000, 32'h0);
    end
    stopTest();
  end
endmodule : tb
